// *** inc/cesr_cfg.svh ***
// Functional notes
// - capture full faulting load/store address for the six address-reporting causes
// - fault address may stay stale for all other causes
// - selector 0x0003 reads the fault address
// - wide addresses: normal read gives low 32 bits, extended read upper bits
// - memory-management exceptions are taken regardless of exception enable
// - integer divide fault flag set on divide by zero or overflow, always
// - selector 0x0005 reads the exception status register
// - status bit 19 marks an excepting instruction in a delay slot
// - cause field bits 27:31 encodes stream through privileged causes
// - cause field encodes storage and TLB miss causes 10000 to 10011
// - unaligned: bit 20 word, bit 21 store, bits 22:26 register number
// - bus errors: bit 20 flags local memory ECC event, rest zero
// - divide: bit 20 clear for zero, set for overflow, rest zero
// - stream: link index in bits 23:26, bits 20:22 zero
// - data storage: bit 20 zone protection, bit 21 store, rest zero
// - instruction storage: bit 20 zone protection, rest zero
// - branch target register exists only with exception support
// - record delay-slot branch targets only while handler flag is clear
// - selector 0x000B reads the branch target register
// - return register gets next instruction address, or branch target in delay slot
// - handler active flag is status word bit 22, set while handling
`ifndef CESR_CFG_SVH
`define CESR_CFG_SVH

`define CESR_ADDR_W     64
`define CESR_WORD_W     32
`define CESR_EXC_SUPPORT 1'b1
`define CESR_SEL_W      16
`define CESR_SEL_MSW    16'h0001
`define CESR_SEL_FAR    16'h0003
`define CESR_SEL_ESR    16'h0005
`define CESR_SEL_BTR    16'h000b
`define CESR_INSN_BYTES 32'h0000_0004

// cause codes, five bits
`define CESR_EC_STREAM  5'h00
`define CESR_EC_UNALIGN 5'h01
`define CESR_EC_ILLEGAL 5'h02
`define CESR_EC_IBUS    5'h03
`define CESR_EC_DBUS    5'h04
`define CESR_EC_DIVIDE  5'h05
`define CESR_EC_FPU     5'h06
`define CESR_EC_PRIV    5'h07
`define CESR_EC_STACK   5'h07
`define CESR_EC_DSTORE  5'h10
`define CESR_EC_ISTORE  5'h11
`define CESR_EC_DTLB    5'h12
`define CESR_EC_ITLB    5'h13

// field positions, little-endian index = 31 - printed bit
`define CESR_DS_POS   12
`define CESR_D20      11
`define CESR_D21      10
`define CESR_RX_HI    9
`define CESR_RX_LO    5
`define CESR_LNK_HI   8
`define CESR_LNK_LO   5
`define CESR_EC_HI    4
`define CESR_EC_LO    0
`define CESR_MSW_EIP  9
`define CESR_MSW_EE   8
`define CESR_MSW_DZO  6
`define CESR_MSW_IE   1

`define CESR_ZERO32   32'h0000_0000
`define CESR_ZERO_ADR 64'h0000_0000_0000_0000

`endif

// *** inc/cesr_pkg.sv ***
`include "cesr_cfg.svh"
package cesr_pkg;

  // exception report from the pipeline, one cycle wide
  typedef struct packed {
    logic                    req;
    logic [4:0]              cause;
    logic                    dslot;
    logic                    word;
    logic                    store;
    logic [4:0]              rx;
    logic                    ecc;
    logic                    div_ovf;
    logic [3:0]              link;
    logic                    zone;
    logic [31:0]             pc;
    logic [`CESR_ADDR_W-1:0] addr;
  } cesr_exc_t;

  // software-visible status word bits handled here
  typedef struct packed {
    logic handler_active_flag;
    logic ee;
    logic ie;
    logic int_divide_fault_flag;
  } cesr_msw_t;

  // move-from-special request
  typedef struct packed {
    logic                   valid;
    logic                   ext;
    logic [`CESR_SEL_W-1:0] sel;
  } cesr_rd_t;

  typedef struct packed {
    logic [`CESR_ADDR_W-1:0] far;
    logic [31:0]             esr;
    logic [31:0]             delay_branch_target;
    logic [31:0]             ret;
    cesr_msw_t               msw;
    logic                    taken;
    logic                    rd_vld;
    logic [31:0]             rd_data;
  } cesr_state_t;

endpackage

// *** verilog/cesr_esr_build.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cesr_cfg.svh"
module cesr_esr_build (
  input  wire cesr_pkg::cesr_exc_t i_exc,
  output logic [31:0]              o_esr
);
  import cesr_pkg::*;

  // status word built from one report; unlisted causes leave detail bits zero
  always_comb begin
    o_esr = `CESR_ZERO32;
    o_esr[`CESR_EC_HI:`CESR_EC_LO] = i_exc.cause;
    o_esr[`CESR_DS_POS] = i_exc.dslot;
    case (i_exc.cause)
      `CESR_EC_UNALIGN: begin
        o_esr[`CESR_D20] = i_exc.word;
        o_esr[`CESR_D21] = i_exc.store;
        o_esr[`CESR_RX_HI:`CESR_RX_LO] = i_exc.rx;
      end
      `CESR_EC_IBUS, `CESR_EC_DBUS: begin
        o_esr[`CESR_D20] = i_exc.ecc;
      end
      `CESR_EC_DIVIDE: begin
        o_esr[`CESR_D20] = i_exc.div_ovf;
      end
      `CESR_EC_STREAM: begin
        o_esr[`CESR_LNK_HI:`CESR_LNK_LO] = i_exc.link;
      end
      `CESR_EC_DSTORE: begin
        o_esr[`CESR_D20] = i_exc.zone;
        o_esr[`CESR_D21] = i_exc.store;
      end
      `CESR_EC_ISTORE: begin
        o_esr[`CESR_D20] = i_exc.zone;
      end
      default: begin
        o_esr[`CESR_D20] = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** verilog/cesr_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cesr_cfg.svh"
module cesr_top (
  input  wire logic                      i_mclk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_ce,
  input  wire cesr_pkg::cesr_exc_t       i_exc,
  input  wire logic                      i_br_valid,
  input  wire logic [31:0]               i_br_target,
  input  wire logic                      i_div_fault,
  input  wire logic                      i_msw_wr,
  input  wire cesr_pkg::cesr_msw_t       i_msw_wdata,
  input  wire logic                      i_exc_return,
  input  wire cesr_pkg::cesr_rd_t        i_rd,
  output logic                           o_exc_taken,
  output logic [31:0]                    o_return_addr,
  output cesr_pkg::cesr_msw_t            o_msw,
  output logic                           o_rd_valid,
  output logic [31:0]                    o_rd_data
);
  import cesr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the incoming report

  cesr_state_t s_r;
  cesr_state_t s_nxt;
  logic [31:0] esr_word;
  logic        mmu_cause;
  logic        addr_cause;
  logic        take;

  cesr_esr_build u_esr_build (
    .i_exc (i_exc),
    .o_esr (esr_word)
  );

  // storage and tlb faults cannot be masked by the enable bit
  assign mmu_cause = (i_exc.cause == `CESR_EC_DSTORE) ||
                     (i_exc.cause == `CESR_EC_ISTORE) ||
                     (i_exc.cause == `CESR_EC_DTLB)   ||
                     (i_exc.cause == `CESR_EC_ITLB);

  // causes that carry a meaningful data or fetch address
  assign addr_cause = mmu_cause ||
                      (i_exc.cause == `CESR_EC_UNALIGN) ||
                      (i_exc.cause == `CESR_EC_DBUS);

  assign take = i_exc.req && (mmu_cause || s_r.msw.ee);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    s_nxt = s_r;
    s_nxt.taken = 1'b0;
    s_nxt.rd_vld = 1'b0;
    s_nxt.rd_data = `CESR_ZERO32;

    // software write of the status word bits first, hardware events override
    if (i_msw_wr) begin
      s_nxt.msw = i_msw_wdata;
    end
    if (i_exc_return) begin
      s_nxt.msw.handler_active_flag = 1'b0;
    end

    // set wins over a clear arriving in the same cycle
    if (i_div_fault) begin
      s_nxt.msw.int_divide_fault_flag = 1'b1;
    end

    // branch target only tracked outside a handler, so the handler sees the
    // target of the interrupted branch even if it branches itself
    if (`CESR_EXC_SUPPORT && i_br_valid && !s_r.msw.handler_active_flag) begin
      s_nxt.delay_branch_target = i_br_target;
    end

    // every exception field loads in the same edge
    if (take) begin
      s_nxt.taken = 1'b1;
      s_nxt.esr = esr_word;
      s_nxt.msw.handler_active_flag = 1'b1;
      if (addr_cause) begin
        s_nxt.far = i_exc.addr;
      end
      // other causes leave the address stale, which software must ignore
      if (i_exc.dslot) begin
        s_nxt.ret = s_nxt.delay_branch_target;
      end else begin
        s_nxt.ret = i_exc.pc + `CESR_INSN_BYTES;
      end
    end

    // move-from-special answers one cycle later from the current contents
    if (i_rd.valid) begin
      s_nxt.rd_vld = 1'b1;
      case (i_rd.sel)
        `CESR_SEL_FAR: begin
          if (i_rd.ext) begin
            s_nxt.rd_data = s_r.far[`CESR_ADDR_W-1:`CESR_WORD_W];
          end else begin
            s_nxt.rd_data = s_r.far[`CESR_WORD_W-1:0];
          end
        end
        `CESR_SEL_ESR: begin
          if (!i_rd.ext) begin
            s_nxt.rd_data = s_r.esr;
          end
        end
        `CESR_SEL_BTR: begin
          if (!i_rd.ext && `CESR_EXC_SUPPORT) begin
            s_nxt.rd_data = s_r.delay_branch_target;
          end
        end
        `CESR_SEL_MSW: begin
          if (!i_rd.ext) begin
            s_nxt.rd_data[`CESR_MSW_EIP] = s_r.msw.handler_active_flag;
            s_nxt.rd_data[`CESR_MSW_EE] = s_r.msw.ee;
            s_nxt.rd_data[`CESR_MSW_DZO] = s_r.msw.int_divide_fault_flag;
            s_nxt.rd_data[`CESR_MSW_IE] = s_r.msw.ie;
          end
        end
        default: begin
          s_nxt.rd_data = `CESR_ZERO32;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while the clock enable is low

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r.far <= `CESR_ZERO_ADR;
      s_r.esr <= `CESR_ZERO32;
      s_r.delay_branch_target <= `CESR_ZERO32;
      s_r.ret <= `CESR_ZERO32;
      s_r.msw <= '0;
      s_r.taken <= 1'b0;
      s_r.rd_vld <= 1'b0;
      s_r.rd_data <= `CESR_ZERO32;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign o_exc_taken = s_r.taken;
  assign o_return_addr = s_r.ret;
  assign o_msw = s_r.msw;
  assign o_rd_valid = s_r.rd_vld;
  assign o_rd_data = s_r.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  logic [4:0] ec_now;
  assign ec_now = s_r.esr[`CESR_EC_HI:`CESR_EC_LO];

  // the captured address must match the report of the taking cycle
  AST_FAR_CAPTURE: assert property (
    i_ce && take && addr_cause |=> s_r.far == $past(i_exc.addr))
    else $error("fault address not captured");

  AST_RD_FAR: assert property (
    i_ce && i_rd.valid && !i_rd.ext && i_rd.sel == `CESR_SEL_FAR
    |=> o_rd_valid && o_rd_data == $past(s_r.far[`CESR_WORD_W-1:0]))
    else $error("fault address read wrong");

  AST_RD_FAR_EXT: assert property (
    i_ce && i_rd.valid && i_rd.ext && i_rd.sel == `CESR_SEL_FAR
    |=> o_rd_data == $past(s_r.far[`CESR_ADDR_W-1:`CESR_WORD_W]))
    else $error("upper fault address read wrong");

  AST_MMU_TAKEN: assert property (
    i_ce && i_exc.req && mmu_cause && !s_r.msw.ee |=> o_exc_taken)
    else $error("mmu exception not taken");

  AST_MASKED: assert property (
    i_ce && i_exc.req && !mmu_cause && !s_r.msw.ee |=> !o_exc_taken)
    else $error("masked exception taken");

  AST_DZO_SET: assert property (
    i_ce && i_div_fault |=> o_msw.int_divide_fault_flag)
    else $error("divide flag not set");

  AST_RD_ESR: assert property (
    i_ce && i_rd.valid && !i_rd.ext && i_rd.sel == `CESR_SEL_ESR
    |=> o_rd_data == $past(s_r.esr))
    else $error("status read wrong");

  AST_DS_FLAG: assert property (
    i_ce && take |=> s_r.esr[`CESR_DS_POS] == $past(i_exc.dslot))
    else $error("delay slot flag wrong");

  AST_CAUSE: assert property (
    i_ce && take |=> ec_now == $past(i_exc.cause))
    else $error("cause code wrong");

  AST_DIV_DETAIL: assert property (
    i_ce && take && i_exc.cause == `CESR_EC_DIVIDE
    |=> s_r.esr[`CESR_D20] == $past(i_exc.div_ovf) && s_r.esr[`CESR_D21:`CESR_RX_LO] == '0)
    else $error("divide detail wrong");

  AST_BTR_HOLD: assert property (
    i_ce && s_r.msw.handler_active_flag |=> $stable(s_r.delay_branch_target))
    else $error("branch target moved in handler");

  AST_RD_BTR: assert property (
    i_ce && i_rd.valid && !i_rd.ext && i_rd.sel == `CESR_SEL_BTR
    |=> o_rd_data == $past(s_r.delay_branch_target))
    else $error("branch target read wrong");

  AST_RET_ADDR: assert property (
    i_ce && take && !i_exc.dslot |=> o_return_addr == $past(i_exc.pc) + `CESR_INSN_BYTES)
    else $error("return address wrong");

  AST_EIP_SET: assert property (
    i_ce && take |=> o_msw.handler_active_flag ##0 o_exc_taken)
    else $error("handler flag not set");

  ////////////////////////////////////////////////////////////////////////////
  // detail field per cause, held against the report of the taking cycle so a
  // swapped field position shows up even when the cause code itself is right

  // width, direction and register number of the misaligned access
  AST_UNALIGN_DETAIL: assert property (
    i_ce && take && i_exc.cause == `CESR_EC_UNALIGN
    |=> s_r.esr[`CESR_D20] == $past(i_exc.word) && s_r.esr[`CESR_D21] == $past(i_exc.store) &&
        s_r.esr[`CESR_RX_HI:`CESR_RX_LO] == $past(i_exc.rx))
    else $error("unaligned detail wrong");

  // only the ecc marker may be set, the rest of the field stays clear
  AST_BUS_DETAIL: assert property (
    i_ce && take && (i_exc.cause == `CESR_EC_IBUS || i_exc.cause == `CESR_EC_DBUS)
    |=> s_r.esr[`CESR_D20] == $past(i_exc.ecc) && s_r.esr[`CESR_D21:`CESR_RX_LO] == '0)
    else $error("bus error detail wrong");

  // link index sits in the low detail bits, the three above it stay clear
  AST_STREAM_DETAIL: assert property (
    i_ce && take && i_exc.cause == `CESR_EC_STREAM
    |=> s_r.esr[`CESR_LNK_HI:`CESR_LNK_LO] == $past(i_exc.link) && s_r.esr[`CESR_D20:`CESR_RX_HI] == '0)
    else $error("stream detail wrong");

  // zone and store markers; the register number slot is unused here
  AST_DSTORE_DETAIL: assert property (
    i_ce && take && i_exc.cause == `CESR_EC_DSTORE
    |=> s_r.esr[`CESR_D20] == $past(i_exc.zone) && s_r.esr[`CESR_D21] == $past(i_exc.store) &&
        s_r.esr[`CESR_RX_HI:`CESR_RX_LO] == '0)
    else $error("data storage detail wrong");

  // a fetch is never a store, so only the zone marker can be set
  AST_ISTORE_DETAIL: assert property (
    i_ce && take && i_exc.cause == `CESR_EC_ISTORE
    |=> s_r.esr[`CESR_D20] == $past(i_exc.zone) && s_r.esr[`CESR_D21:`CESR_RX_LO] == '0)
    else $error("instruction storage detail wrong");

  // reserved detail bits read zero whatever the pipeline left on the report;
  // stack violation shares the privileged code and falls under the same test
  AST_RESERVED_ZERO: assert property (
    i_ce && take && (i_exc.cause == `CESR_EC_ILLEGAL || i_exc.cause == `CESR_EC_FPU ||
                     i_exc.cause == `CESR_EC_PRIV)
    |=> s_r.esr[`CESR_D20:`CESR_RX_LO] == '0)
    else $error("reserved detail bits set");

  // storage and tlb faults report one of the four memory-management codes
  AST_MMU_CODE: assert property (
    i_ce && take && mmu_cause
    |=> ec_now inside {`CESR_EC_DSTORE, `CESR_EC_ISTORE, `CESR_EC_DTLB, `CESR_EC_ITLB})
    else $error("mmu cause code wrong");

  // one edge loads every field, so a handler never reads a half-updated record
  AST_ONE_EDGE: assert property (
    i_ce && take && addr_cause
    |=> ec_now == $past(i_exc.cause) && s_r.esr[`CESR_DS_POS] == $past(i_exc.dslot) &&
        s_r.far == $past(i_exc.addr) && o_exc_taken)
    else $error("exception record split over cycles");

  ////////////////////////////////////////////////////////////////////////////
  // handler flag, branch target, divide flag and return address

  // branches outside a handler always land in the target register
  AST_BTR_RECORD: assert property (
    i_ce && i_br_valid && !s_r.msw.handler_active_flag |=> s_r.delay_branch_target == $past(i_br_target))
    else $error("branch target not recorded");

  // a delay-slot fault returns to the recorded target, not past the slot
  AST_RET_DSLOT: assert property (
    i_ce && take && i_exc.dslot && !i_br_valid |=> o_return_addr == $past(s_r.delay_branch_target))
    else $error("delay slot return address wrong");

  // a return with no new take leaves the handler
  AST_EIP_CLEAR: assert property (
    i_ce && i_exc_return && !take |=> !o_msw.handler_active_flag)
    else $error("handler flag not cleared");

  // the flag is sticky: only a software write may clear it
  AST_DZO_STICKY: assert property (
    i_ce && !i_div_fault && !i_msw_wr |=> o_msw.int_divide_fault_flag == $past(o_msw.int_divide_fault_flag))
    else $error("divide flag changed by itself");

  // the handler flag does not block a take, only the enable bit gates it
  AST_ENABLED_TAKEN: assert property (
    i_ce && i_exc.req && s_r.msw.ee |=> o_exc_taken)
    else $error("enabled exception not taken");

  // the taken indication is a single pulse per take
  AST_TAKEN_PULSE: assert property (
    i_ce && !take |=> !o_exc_taken)
    else $error("taken flag without a take");

  // return address only moves when an exception is taken
  AST_RET_HOLD: assert property (
    i_ce && !take |=> $stable(o_return_addr))
    else $error("return address moved without a take");

  ////////////////////////////////////////////////////////////////////////////
  // move-from-special answers

  AST_RD_MSW: assert property (
    i_ce && i_rd.valid && !i_rd.ext && i_rd.sel == `CESR_SEL_MSW
    |=> o_rd_data[`CESR_MSW_EIP] == $past(s_r.msw.handler_active_flag) && o_rd_data[`CESR_MSW_DZO] == $past(s_r.msw.int_divide_fault_flag))
    else $error("status word read wrong");

  // extended reads only mean something for the wide fault address
  AST_RD_EXT_ZERO: assert property (
    i_ce && i_rd.valid && i_rd.ext && i_rd.sel != `CESR_SEL_FAR |=> o_rd_valid && o_rd_data == '0)
    else $error("extended read of a narrow register not zero");

  // the answer bus idles at zero so a stray sample never shows stale data
  AST_RD_IDLE: assert property (
    i_ce && !i_rd.valid |=> !o_rd_valid && o_rd_data == '0)
    else $error("read answer without a request");

  COV_MMU_MASKED: cover property (i_ce && take && mmu_cause && !s_r.msw.ee);
  COV_DSLOT: cover property (i_ce && take && i_exc.dslot);
  COV_EXT_READ: cover property (i_ce && i_rd.valid && i_rd.ext && i_rd.sel == `CESR_SEL_FAR);
  COV_DIV_CLR: cover property (i_ce && i_div_fault && i_msw_wr && !i_msw_wdata.int_divide_fault_flag);
  COV_BR_IN_HANDLER: cover property (i_ce && i_br_valid && s_r.msw.handler_active_flag);

endmodule
`default_nettype wire

// *** bench/cesr_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cesr_cfg.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t value mismatch got %h exp %h", $time, got, exp); end end
module cesr_top_bench;
  import cesr_pkg::*;
  logic                  i_mclk;
  logic                  i_resetn;
  logic                  i_ce;
  cesr_exc_t             i_exc;
  logic                  i_br_valid;
  logic [31:0]           i_br_target;
  logic                  i_div_fault;
  logic                  i_msw_wr;
  cesr_msw_t             i_msw_wdata;
  logic                  i_exc_return;
  cesr_rd_t              i_rd;
  logic                  o_exc_taken;
  logic [31:0]           o_return_addr;
  cesr_msw_t             o_msw;
  logic                  o_rd_valid;
  logic [31:0]           o_rd_data;
  int                    n_mismatch;
  int                    check_count;
  int                    cyc;
  logic [31:0]           exp_q[$];
  logic [31:0]           exp_rd;
  logic [31:0]           rv;
  logic [31:0]           exp_btr;
  logic [31:0]           exp_esr;
  logic [15:0]           lfsr_q;
  cesr_exc_t             e;
  logic [4:0]            causes[13];

  cesr_top cesr_top_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_exc(i_exc),
    .i_br_valid(i_br_valid), .i_br_target(i_br_target), .i_div_fault(i_div_fault), .i_msw_wr(i_msw_wr),
    .i_msw_wdata(i_msw_wdata), .i_exc_return(i_exc_return), .i_rd(i_rd), .o_exc_taken(o_exc_taken),
    .o_return_addr(o_return_addr), .o_msw(o_msw), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and cycle ceiling, a hang is cut short rather than left to run
  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // read results are matched oldest first against the notes of the driver,
  // sampled mid-cycle where the registered answer has settled
  always @(negedge i_mclk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] %0t read answer without request", $time);
      end else begin
        exp_rd = exp_q.pop_front();
        `CHK(o_rd_data, exp_rd)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // 16-bit lfsr, two steps make one 32-bit word
  function logic [31:0] rnd();
    logic [31:0] r;
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    r[15:0] = lfsr_q;
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    r[31:16] = lfsr_q;
    return r;
  endfunction

  function logic is_adr(logic [4:0] c);
    return c inside {`CESR_EC_UNALIGN, `CESR_EC_DBUS, `CESR_EC_DSTORE, `CESR_EC_ISTORE, `CESR_EC_DTLB, `CESR_EC_ITLB};
  endfunction

  // expected status word, detail bits only where the cause defines them
  function logic [31:0] esr_of(cesr_exc_t x);
    logic [31:0] r;
    r = `CESR_ZERO32;
    r[`CESR_EC_HI:`CESR_EC_LO] = x.cause;
    r[`CESR_DS_POS] = x.dslot;
    case (x.cause)
      `CESR_EC_UNALIGN: begin
        r[`CESR_D20] = x.word;
        r[`CESR_D21] = x.store;
        r[`CESR_RX_HI:`CESR_RX_LO] = x.rx;
      end
      `CESR_EC_IBUS, `CESR_EC_DBUS: r[`CESR_D20] = x.ecc;
      `CESR_EC_DIVIDE: r[`CESR_D20] = x.div_ovf;
      `CESR_EC_STREAM: r[`CESR_LNK_HI:`CESR_LNK_LO] = x.link;
      `CESR_EC_DSTORE: begin
        r[`CESR_D20] = x.zone;
        r[`CESR_D21] = x.store;
      end
      `CESR_EC_ISTORE: r[`CESR_D20] = x.zone;
      default: ;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // drivers: each raises its pulse for exactly one edge
  task rd(input logic [15:0] sel, input logic ext, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd <= '{valid: 1'b1, ext: ext, sel: sel};
    exp_q.push_back(exp);
    @(posedge i_mclk);
    i_rd <= '0;
  endtask

  task exc(input cesr_exc_t x, input logic take);
    @(posedge i_mclk);
    i_exc <= x;
    @(posedge i_mclk);
    i_exc <= '0;
    #1;
    `CHK(o_exc_taken, take)
    if (take) begin
      `CHK(o_msw.handler_active_flag, 1'b1)
      `CHK(o_return_addr, x.dslot ? exp_btr : x.pc + `CESR_INSN_BYTES)
      exp_esr = esr_of(x);
    end
  endtask

  task msw_wr(input cesr_msw_t v);
    @(posedge i_mclk);
    i_msw_wr <= 1'b1;
    i_msw_wdata <= v;
    @(posedge i_mclk);
    i_msw_wr <= 1'b0;
    #1;
    `CHK(o_msw, v)
  endtask

  task pulse_ret();
    @(posedge i_mclk);
    i_exc_return <= 1'b1;
    @(posedge i_mclk);
    i_exc_return <= 1'b0;
    #1;
    `CHK(o_msw.handler_active_flag, 1'b0)
  endtask

  // the target only counts when no handler is active
  task br(input logic [31:0] t, input logic record);
    @(posedge i_mclk);
    i_br_valid <= 1'b1;
    i_br_target <= t;
    @(posedge i_mclk);
    i_br_valid <= 1'b0;
    if (record) exp_btr = t;
  endtask

  task give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    causes = '{`CESR_EC_STREAM, `CESR_EC_UNALIGN, `CESR_EC_ILLEGAL, `CESR_EC_IBUS, `CESR_EC_DBUS,
      `CESR_EC_DIVIDE, `CESR_EC_FPU, `CESR_EC_PRIV, `CESR_EC_STACK, `CESR_EC_DSTORE, `CESR_EC_ISTORE,
      `CESR_EC_DTLB, `CESR_EC_ITLB};
    {i_mclk, i_resetn, i_ce, i_exc, i_br_valid, i_br_target, i_div_fault} = '0;
    {i_msw_wr, i_msw_wdata, i_exc_return, i_rd, n_mismatch, check_count, cyc} = '0;
    lfsr_q = 16'h7b6e;
    exp_btr = `CESR_ZERO32;
    repeat (16) @(posedge i_mclk);
    i_resetn <= 1'b1;
    i_ce <= 1'b1;
    // reset contents, then an unknown selector and a stray extended read
    rd(`CESR_SEL_FAR, 1'b0, `CESR_ZERO32);
    rd(`CESR_SEL_ESR, 1'b0, `CESR_ZERO32);
    rd(`CESR_SEL_BTR, 1'b0, `CESR_ZERO32);
    rd(16'h0042, 1'b0, `CESR_ZERO32);
    rd(`CESR_SEL_ESR, 1'b1, `CESR_ZERO32);
    msw_wr('{handler_active_flag: 1'b0, ee: 1'b1, ie: 1'b1, int_divide_fault_flag: 1'b0});
    // every cause once, random detail fields and addresses
    foreach (causes[i]) begin
      e = '0;
      e.req = 1'b1;
      e.cause = causes[i];
      rv = rnd();
      {e.dslot, e.word, e.store, e.rx, e.ecc, e.div_ovf, e.link, e.zone} = rv[14:0];
      e.pc = rnd();
      e.addr = {rnd(), rnd()};
      br(rnd(), 1'b1);
      exc(e, 1'b1);
      rd(`CESR_SEL_ESR, 1'b0, exp_esr);
      if (is_adr(e.cause)) begin
        rd(`CESR_SEL_FAR, 1'b0, e.addr[31:0]);
        rd(`CESR_SEL_FAR, 1'b1, e.addr[63:32]);
      end
      pulse_ret();
    end
    // exceptions disabled: ordinary cause refused, data TLB miss still taken
    msw_wr('{handler_active_flag: 1'b0, ee: 1'b0, ie: 1'b1, int_divide_fault_flag: 1'b0});
    e.cause = `CESR_EC_ILLEGAL;
    exc(e, 1'b0);
    rd(`CESR_SEL_ESR, 1'b0, exp_esr);
    e.cause = `CESR_EC_DTLB;
    e.addr = {rnd(), rnd()};
    exc(e, 1'b1);
    rd(`CESR_SEL_FAR, 1'b0, e.addr[31:0]);
    // handler active: branch target must not move
    br(rnd(), 1'b0);
    rd(`CESR_SEL_BTR, 1'b0, exp_btr);
    rd(`CESR_SEL_MSW, 1'b0, 32'h0000_0202);
    pulse_ret();
    // divide fault flag, then frozen while the clock enable is low
    @(posedge i_mclk);
    i_div_fault <= 1'b1;
    @(posedge i_mclk);
    i_div_fault <= 1'b0;
    #1;
    `CHK(o_msw.int_divide_fault_flag, 1'b1)
    msw_wr('{handler_active_flag: 1'b0, ee: 1'b0, ie: 1'b1, int_divide_fault_flag: 1'b0});
    @(posedge i_mclk);
    i_ce <= 1'b0;
    i_div_fault <= 1'b1;
    @(posedge i_mclk);
    i_div_fault <= 1'b0;
    i_ce <= 1'b1;
    #1;
    `CHK(o_msw.int_divide_fault_flag, 1'b0)
    // divide fault and a software clear in one cycle: the hardware set wins
    @(posedge i_mclk);
    i_div_fault <= 1'b1;
    i_msw_wr <= 1'b1;
    i_msw_wdata <= '{handler_active_flag: 1'b0, ee: 1'b0, ie: 1'b1, int_divide_fault_flag: 1'b0};
    @(posedge i_mclk);
    i_div_fault <= 1'b0;
    i_msw_wr <= 1'b0;
    #1;
    `CHK(o_msw.int_divide_fault_flag, 1'b1)
    repeat (4) @(posedge i_mclk);
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule
`default_nettype wire
